// file: hdl/ncp_pkg.sv
`default_nettype none
package ncp_pkg;
    // data word and link widths
    localparam int          WORD_W        = 16;
    localparam int          CMD_W         = 2;
    localparam int          FIFO_W        = CMD_W + WORD_W;
    localparam int          FIFO_DEPTH    = 4;
    // host word addresses of the coprocessor
    localparam logic [15:0] IO_ADDR_OPCODE   = 16'h00F8;
    localparam logic [15:0] IO_ADDR_OPERAND  = 16'h00FA;
    localparam logic [15:0] IO_ADDR_POINTER  = 16'h00FC;
    localparam logic [15:0] IO_ADDR_RESERVED = 16'h00FE;
    // command codes on command_bit1/command_bit0
    localparam logic [1:0]  CMD_OPCODE    = 2'h0;
    localparam logic [1:0]  CMD_OPERAND   = 2'h1;
    localparam logic [1:0]  CMD_POINTER   = 2'h2;
    localparam logic [1:0]  CMD_RESERVED  = 2'h3;
    // select levels that address the coprocessor
    localparam logic        SEL_HIGH_ON   = 1'b1;
    localparam logic        SEL_LOW_ON    = 1'b0;
    // host clock divided by three in clock mode 0
    localparam logic [1:0]  CLK_DIV_LAST  = 2'h2;
    // sampled pin vector width
    localparam int          PIN_W         = 13 + WORD_W;
    // reset values
    localparam logic        BUSY_N_RST    = 1'b1;
    localparam logic        ERROR_N_RST   = 1'b1;
    localparam logic [WORD_W-1:0] DATA_RST = 16'h0000;

    typedef enum logic [2:0] {
        NCP_IDLE = 3'b001,
        NCP_RUN  = 3'b010,
        NCP_DONE = 3'b100
    } ncp_state_e;
endpackage
`default_nettype wire

// file: hdl/ncp_fifo_if.sv
`default_nettype none
interface ncp_fifo_if #(parameter int W = 18);
    logic         fill_valid;
    logic         fill_ready;
    logic [W-1:0] fill_data;
    logic         drain_valid;
    logic         drain_ready;
    logic [W-1:0] drain_data;
    modport fill  (output fill_valid, fill_data, input fill_ready);
    modport drain (input drain_valid, drain_data, output drain_ready);
    modport fifo  (input fill_valid, fill_data, drain_ready,
                   output fill_ready, drain_valid, drain_data);
endinterface
`default_nettype wire

// file: hdl/ncp_fifo.sv
`default_nettype none
module ncp_fifo #(
    parameter int W = 18,
    parameter int D = 4
) (
    input  wire logic core_clk,
    input  wire logic reset,
    ncp_fifo_if.fifo  f
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0]   count_reg;
    logic          push;
    logic          pop;

    assign f.fill_ready  = (count_reg != (AW+1)'(D));
    assign f.drain_valid = (count_reg != '0);
    assign f.drain_data  = mem[rd_ptr_reg];
    assign push = f.fill_valid && f.fill_ready;
    assign pop  = f.drain_valid && f.drain_ready;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= f.fill_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(D-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(D-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: hdl/ncp_host_port.sv
`default_nettype none
// Notes on behaviour
// - decode three addresses as select 10, commands 00/01/10
// - fourth address reserved, no command function
// - command bits from A1/A2, strobes from io commands
// - io transfers finish with zero wait states
// - busy held active while instruction executes
// - error asserted before busy releases
// - watch status, ready, reset, hold, clock lines
// - clock mode low divides host clock by three
// - clock mode high runs from dedicated clock
// - request held high until acknowledge goes low
// - request only while busy after an escape
module ncp_host_port
    import ncp_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              clock_mode_select,
    input  wire logic              ext_clk_pin,
    input  wire logic              ext_select_high,
    input  wire logic              ext_select_low,
    input  wire logic              command_bit0,
    input  wire logic              command_bit1,
    input  wire logic              ext_read_strobe_n,
    input  wire logic              ext_write_strobe_n,
    input  wire logic              bus_status_1_n,
    input  wire logic              bus_status_0_n,
    input  wire logic              code_or_int_ack_status,
    input  wire logic              host_ready_n,
    input  wire logic              host_reset,
    input  wire logic              hold_acknowledge,
    input  wire logic              operand_transfer_ack_n,
    input  wire logic [WORD_W-1:0] host_data_in,
    output logic [WORD_W-1:0]      host_data_out,
    output logic                   host_data_oe,
    output logic                   busy_n,
    output logic                   error_n,
    output logic                   operand_transfer_request,
    output logic                   escape_cycle_active,
    output logic                   exec_tick,
    output logic                   exec_valid,
    output logic [CMD_W-1:0]       exec_cmd,
    output logic [WORD_W-1:0]      exec_data,
    input  wire logic              exec_ready,
    input  wire logic              exec_done,
    input  wire logic              exec_exception,
    input  wire logic              exec_operand_need,
    input  wire logic [WORD_W-1:0] exec_status_word,
    input  wire logic [WORD_W-1:0] exec_read_data
);
    logic [PIN_W-1:0]  sync1_reg;
    logic [PIN_W-1:0]  sync2_reg;
    logic [PIN_W-1:0]  pins_raw;
    logic              clk_s, sel_hi_s, sel_lo_s, rd_n_s, wr_n_s;
    logic              st1_n_s, st0_n_s, cod_s, rdy_n_s, hrst_s, hold_acknowledge_s;
    logic              ack_n_s;
    logic              mode_s;
    logic [1:0]        cmd_sync1_reg;
    logic [1:0]        cmd_sync2_reg;
    logic [1:0]        cmd_s;
    logic [WORD_W-1:0] data_s;
    logic              clk_prev_reg;
    logic              wr_n_prev_reg;
    logic              accept;
    logic              done_seen_reg;
    logic              exc_seen_reg;
    logic              req_next;
    logic [1:0]        div_cnt_reg;
    logic              tick;
    logic              selected;
    logic              wr_end;
    logic              wr_sel_reg;
    logic [1:0]        wr_cmd_reg;
    logic [WORD_W-1:0] wr_data_reg;
    logic              soft_reset;
    logic              opcode_push;
    ncp_state_e        state_reg;
    ncp_state_e        state_next;

    ncp_fifo_if #(.W(FIFO_W)) fq ();

    ncp_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
        .core_clk (core_clk),
        .reset    (reset),
        .f        (fq.fifo)
    );

    function automatic logic sel_match(input logic hi, input logic lo);
        return (hi == SEL_HIGH_ON) && (lo == SEL_LOW_ON);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    assign pins_raw = {ext_clk_pin, ext_select_high, ext_select_low,
                       ext_read_strobe_n, ext_write_strobe_n,
                       bus_status_1_n, bus_status_0_n,
                       code_or_int_ack_status, host_ready_n, host_reset,
                       hold_acknowledge, operand_transfer_ack_n,
                       clock_mode_select, host_data_in};

    always_ff @(posedge core_clk) begin
        sync1_reg     <= pins_raw;
        sync2_reg     <= sync1_reg;
        cmd_sync1_reg <= {command_bit1, command_bit0};
        cmd_sync2_reg <= cmd_sync1_reg;
    end

    assign {clk_s, sel_hi_s, sel_lo_s, rd_n_s, wr_n_s, st1_n_s, st0_n_s,
            cod_s, rdy_n_s, hrst_s, hold_acknowledge_s, ack_n_s, mode_s,
            data_s} = sync2_reg;
    // command bits follow the latched address lines
    assign cmd_s      = cmd_sync2_reg;
    assign selected   = sel_match(sel_hi_s, sel_lo_s);
    assign soft_reset = reset || hrst_s;

    ////////////////////////////////////////////////////////////////////////
    // execution rate
    always_ff @(posedge core_clk) begin
        if (reset) begin
            div_cnt_reg <= '0;
        end else if (div_cnt_reg == CLK_DIV_LAST) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 2'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            clk_prev_reg <= 1'b1;
        end else begin
            clk_prev_reg <= clk_s;
        end
    end

    assign tick = mode_s ? (clk_s && !clk_prev_reg)
                         : (div_cnt_reg == CLK_DIV_LAST);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            exec_tick <= 1'b0;
        end else begin
            exec_tick <= tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host write cycles: capture while the strobe is low, act at its end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_n_prev_reg <= 1'b1;
            wr_sel_reg    <= 1'b0;
            wr_cmd_reg    <= CMD_RESERVED;
            wr_data_reg   <= DATA_RST;
        end else begin
            wr_n_prev_reg <= wr_n_s;
            if (!wr_n_s) begin
                wr_sel_reg  <= selected;
                wr_cmd_reg  <= cmd_s;
                wr_data_reg <= data_s;
            end
        end
    end

    assign wr_end = wr_n_s && !wr_n_prev_reg;
    // no ready is needed: the cycle is taken when the strobe ends
    assign accept = wr_end && wr_sel_reg && !soft_reset
                    && (wr_cmd_reg != CMD_RESERVED);
    assign opcode_push = accept && (wr_cmd_reg == CMD_OPCODE);

    assign fq.fill_valid = accept;
    assign fq.fill_data  = {wr_cmd_reg, wr_data_reg};

    // host bus cycle aimed at the coprocessor, until ready
    always_ff @(posedge core_clk) begin
        if (soft_reset) begin
            escape_cycle_active <= 1'b0;
        end else begin
            escape_cycle_active <= (escape_cycle_active && rdy_n_s)
                || (selected && cod_s && !hold_acknowledge_s
                    && !(st1_n_s && st0_n_s)
                    && !(rd_n_s && wr_n_s));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host read cycles
    always_ff @(posedge core_clk) begin
        if (soft_reset) begin
            host_data_oe  <= 1'b0;
            host_data_out <= DATA_RST;
        end else begin
            host_data_oe  <= selected && !rd_n_s
                             && (cmd_s != CMD_RESERVED);
            host_data_out <= (cmd_s == CMD_OPCODE) ? exec_status_word
                                                   : exec_read_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command stage towards the execution unit
    assign fq.drain_ready = !exec_valid || exec_ready;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            exec_valid <= 1'b0;
            exec_cmd   <= CMD_OPCODE;
            exec_data  <= DATA_RST;
        end else if (fq.drain_ready) begin
            exec_valid <= fq.drain_valid;
            exec_cmd   <= fq.drain_data[FIFO_W-1:WORD_W];
            exec_data  <= fq.drain_data[WORD_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            NCP_IDLE: begin
                if (opcode_push) begin
                    state_next = NCP_RUN;
                end
            end
            NCP_RUN: begin
                // a pending request holds the instruction open
                if (done_seen_reg && !operand_transfer_request) begin
                    state_next = NCP_DONE;
                end
            end
            NCP_DONE: begin
                state_next = NCP_IDLE;
            end
            default: begin
                state_next = NCP_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (soft_reset) begin
            state_reg <= NCP_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (soft_reset) begin
            busy_n <= BUSY_N_RST;
        end else begin
            busy_n <= (state_next == NCP_IDLE);
        end
    end

    always_ff @(posedge core_clk) begin
        if (soft_reset || opcode_push) begin
            done_seen_reg <= 1'b0;
            exc_seen_reg  <= 1'b0;
        end else if ((state_reg == NCP_RUN) && exec_done) begin
            done_seen_reg <= 1'b1;
            exc_seen_reg  <= exec_exception;
        end
    end

    // error falls one cycle before busy is released
    always_ff @(posedge core_clk) begin
        if (soft_reset) begin
            error_n <= ERROR_N_RST;
        end else if (opcode_push) begin
            error_n <= 1'b1;
        end else if ((state_reg == NCP_RUN) && (state_next == NCP_DONE)
                     && exc_seen_reg) begin
            error_n <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operand transfer request
    always_comb begin
        req_next = 1'b0;
        if (state_reg == NCP_RUN) begin
            if (operand_transfer_request) begin
                req_next = ack_n_s;
            end else begin
                req_next = exec_operand_need && !done_seen_reg;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (soft_reset) begin
            operand_transfer_request <= 1'b0;
        end else begin
            operand_transfer_request <= req_next;
        end
    end
endmodule
`default_nettype wire

// file: dv/ncp_host_port_asserts.sv
`default_nettype none
module ncp_chk
    import ncp_pkg::*;
(
    input wire logic             core_clk,
    input wire logic             reset,
    input wire logic             clock_mode_select,
    input wire logic             busy_n,
    input wire logic             error_n,
    input wire logic             operand_transfer_request,
    input wire logic             operand_transfer_ack_n,
    input wire logic             exec_tick,
    input wire logic             exec_valid,
    input wire logic [CMD_W-1:0] exec_cmd,
    input wire logic             exec_ready,
    input wire logic             exec_operand_need
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    rst_vals_a: assert property ($past(reset) |-> busy_n && error_n)
        else $error("reset values wrong");
    req_busy_a: assert property (operand_transfer_request |-> !busy_n)
        else $error("request without busy");
    err_early_a: assert property ($fell(error_n) |-> !busy_n)
        else $error("error after busy release");
    req_hold_a: assert property (
        operand_transfer_request && !busy_n && operand_transfer_ack_n
        && $past(operand_transfer_ack_n)
        && $past(operand_transfer_ack_n, 2)
        |=> operand_transfer_request || busy_n)
        else $error("request dropped early");
    no_rsvd_a: assert property (exec_valid |-> exec_cmd != CMD_RESERVED)
        else $error("reserved command issued");
    div_three_a: assert property (!clock_mode_select && exec_tick
        ##1 !clock_mode_select |-> !exec_tick ##1 !exec_tick ##1 exec_tick)
        else $error("tick not one third");
    cmd_stable_a: assert property (exec_valid && !exec_ready
        |=> exec_valid && $stable(exec_cmd))
        else $error("command changed while waiting");
    need_req_a: assert property ($rose(operand_transfer_request)
        |-> exec_operand_need || $past(exec_operand_need))
        else $error("request without need");
endmodule
bind ncp_host_port ncp_chk u_chk (.*);
`default_nettype wire

// file: dv/ncp_host_model.sv
`default_nettype none
module ncp_host_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic req,
    output var logic ack_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_reg;
    // ack on first bus operation after a short wait
    // channel is set up before any request; one io op plus memory op
    // per transfer; hold requests would rank above it
    always_ff @(posedge core_clk) begin
        ack_n <= 1'b1;
        wait_reg <= 2'h0;
        if (!reset && req && ack_n) begin
            wait_reg <= wait_reg + 2'h1;
            if (wait_reg == 2'h2) begin
                ack_n <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/tb_ncp_host_port.sv
`default_nettype none
module tb_ncp_host_port;
    import ncp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, cm = 0, sh = 0, sl = 1, c0 = 0, c1 = 0;
    logic wr_n = 1, rd_n = 1, rdy = 0, done = 0, exc = 0, need = 0;
    logic req, ack_n, ext_ck = 0, esc_seen = 0;
    logic bsy_n, err_n, ev, oe, coprocessor_escape_instr, tk;
    logic [1:0] cmd;
    logic [15:0] dout, ed, rdat = 16'hA5C3;
    // rows: code sent in [2:1], exec_valid expected in [0]
    logic [2:0] rows [4] = '{3'b001, 3'b011, 3'b101, 3'b110};
    int num_errors = 0, checked = 0, cyc = 0, n, ticks;
    always #10 clk = ~clk;
    always @(posedge clk) ext_ck <= ~ext_ck;
    always @(posedge clk) if (coprocessor_escape_instr === 1'b1) esc_seen <= 1'b1;
    ncp_host_port dut (.core_clk(clk), .reset(rst), .clock_mode_select(cm),
        .ext_clk_pin(ext_ck), .ext_select_high(sh), .ext_select_low(sl),
        .command_bit0(c0), .command_bit1(c1), .ext_read_strobe_n(rd_n),
        .ext_write_strobe_n(wr_n), .bus_status_1_n(wr_n),
        .bus_status_0_n(1'b1), .code_or_int_ack_status(1'b1),
        .host_ready_n(~wr_n), .host_reset(rst), .hold_acknowledge(1'b0),
        .operand_transfer_ack_n(ack_n), .host_data_in(16'h1234),
        .host_data_out(dout), .host_data_oe(oe), .busy_n(bsy_n),
        .error_n(err_n), .operand_transfer_request(req),
        .escape_cycle_active(coprocessor_escape_instr), .exec_tick(tk), .exec_valid(ev),
        .exec_cmd(cmd), .exec_data(ed), .exec_ready(rdy),
        .exec_done(done), .exec_exception(exc),
        .exec_operand_need(need), .exec_status_word(16'h0000),
        .exec_read_data(rdat));
    ncp_host_model host (.core_clk(clk), .reset(rst), .req(req),
        .ack_n(ack_n));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one read cycle; the bench leaves the data lines to the device
    task automatic hrd(input logic [1:0] c);
        @(posedge clk);
        {sh, sl, c1, c0, rd_n} <= {SEL_HIGH_ON, SEL_LOW_ON, c, 1'b0};
        @(posedge clk);
        {sh, sl, rd_n} <= 3'b011;
        for (n = 0; n < 8 && oe !== 1'b1; n++) @(negedge clk);
    endtask
    // one zero-wait write cycle, then wait for the command
    task automatic hwr(input logic [1:0] c);
        @(posedge clk);
        {sh, sl, c1, c0, wr_n} <= {SEL_HIGH_ON, SEL_LOW_ON, c, 1'b0};
        @(posedge clk);
        {sh, sl, wr_n} <= 3'b011;
        for (n = 0; n < 8 && ev !== 1'b1; n++) @(negedge clk);
    endtask
    always @(posedge clk) if (++cyc == 4000) begin
        num_errors++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        @(negedge clk);
        check({bsy_n, err_n, req, coprocessor_escape_instr}, {BUSY_N_RST, ERROR_N_RST, 2'b00});
        for (int i = 0; i < 4; i++) begin
            hwr(rows[i][2:1]);
            check(ev, rows[i][0]);
            if (rows[i][0]) check(cmd, rows[i][2:1]);
            if (rows[i][0]) check(ed, 16'h1234);
            rdy <= 1;
            @(posedge clk);
            rdy <= 0;
        end
        check({bsy_n, esc_seen}, 2'b01);
        {exc, done} <= 2'b01;
        @(posedge clk);
        done <= 0;
        for (n = 0; n < 8 && bsy_n !== 1'b1; n++) @(negedge clk);
        check({bsy_n, err_n}, 2'b11);
        hrd(CMD_OPERAND);
        check(oe, 1'b1);
        check(dout, rdat);
        @(negedge clk);
        check(oe, 1'b0);
        hwr(CMD_OPCODE);
        rdy <= 1;
        need <= 1;
        for (n = 0; n < 20 && req !== 1'b1; n++) @(negedge clk);
        check({req, bsy_n}, 2'b10);
        need <= 0;
        @(posedge clk);
        {exc, done} <= 2'b11;
        @(posedge clk);
        {exc, done} <= 2'b00;
        for (n = 0; n < 20 && err_n !== 1'b0; n++) @(negedge clk);
        check({err_n, bsy_n}, 2'b00);
        ticks = 0;
        repeat (30) @(negedge clk) ticks += tk;
        check(ticks[15:0], 16'h000A);
        @(posedge clk);
        cm <= 1'b1;
        repeat (6) @(posedge clk);
        ticks = 0;
        repeat (40) @(negedge clk) ticks += tk;
        check(ticks[15:0], 16'h0014);
        conclude();
    end
endmodule
`default_nettype wire
